// file: sfc_pkg.sv
// Constants and types shared by the serial flash command logic.
// Assumes a host that frames every command with chip select and clocks the link itself.
package sfc_pkg;
    localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] FAST_READ_CMD = 8'h0b;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
    localparam logic [7:0] DUAL_READ_CMD = 8'h3b;

    // Whole bytes seen in a frame; the counter saturates at its top value.
    localparam logic [2:0] ONE_BYTE = 3'h1;
    localparam logic [2:0] STATUS_FRAME_BYTES = 3'h2;
    localparam logic [2:0] ADDR_LAST_BYTE = 3'h3;
    localparam logic [2:0] ADDR_FRAME_BYTES = 3'h4;
    localparam logic [2:0] PROG_MIN_BYTES = 3'h5;
    localparam logic [2:0] BYTES_SAT = 3'h7;

    localparam int PAGE_AW = 8;
    localparam int PAGE_BYTES = 2 ** PAGE_AW;
    localparam int SECTOR_AW = 12;
    localparam int SECTOR_BYTES = 2 ** SECTOR_AW;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned STATUS_WRITE_TIME_US = 1000;
    localparam int unsigned PAGE_PROGRAM_TIME_US = 1000;
    localparam int unsigned SECTOR_ERASE_TIME_US = 10000;

    typedef struct packed {
        logic status_protect_bit;
        logic [1:0] zero;
        logic [2:0] block_protect_bits;
        logic write_enable_latch;
        logic write_in_progress;
    } sfc_status_t;

    // What the link side leaves behind at the end of a frame.
    typedef struct packed {
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [7:0] data;
        logic [2:0] bytes;
        logic [2:0] bits;
        logic tog;
    } sfc_frame_t;

    typedef enum logic [2:0] {RM_NONE, RM_STATUS, RM_READ, RM_FAST, RM_DUAL} sfc_rd_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WSTAT, ST_PROG, ST_ERASE} sfc_state_t;
endpackage

// file: sfc_flash.sv
// Serial flash command interpreter: status, reads, page program and sector erase.
// Assumes the host clocks the link on sck_in only while chip select is low, and
// keeps chip select high for several clk_in periods between frames.
`timescale 1ns/1ps
module sfc_flash #(
    parameter int AW = 17,
    parameter int unsigned TW_CYC = sfc_pkg::STATUS_WRITE_TIME_US * sfc_pkg::CLK_MHZ,
    parameter int unsigned TPP_CYC = sfc_pkg::PAGE_PROGRAM_TIME_US * sfc_pkg::CLK_MHZ,
    parameter int unsigned TSE_CYC = sfc_pkg::SECTOR_ERASE_TIME_US * sfc_pkg::CLK_MHZ
) (
    // Core clock and reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    // Serial link from the host.
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic io0_in,
    input wire logic wp_n_in,
    // Serial link to the host.
    output logic io0_out,
    output logic io0_oe_out,
    output logic so_out,
    output logic so_oe_out,
    // Device state.
    output sfc_pkg::sfc_status_t status_out
);
    localparam int MEM_BYTES = 2 ** AW;

    // Array contents are undefined until programmed or erased.
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] pbuf [sfc_pkg::PAGE_BYTES];
    logic [sfc_pkg::PAGE_BYTES-1:0] pmask, next_pmask;

    // Link side, rising edges of sck_in.
    sfc_pkg::sfc_frame_t frm, next_frm;
    sfc_pkg::sfc_rd_mode_t mode, next_mode, cur_mode;
    sfc_pkg::sfc_status_t stat_s1, stat_s2;
    logic [7:0] shreg, rx_byte, sr_shadow, next_sr_shadow;
    logic [7:0] pg_ptr, next_pg_ptr;
    logic [23:0] rd_addr, next_rd_addr;
    logic [2:0] cur_bits, cur_bytes, step;
    logic out_on, next_out_on, cur_on, prog_ok, next_prog_ok, byte_done, pb_we;
    logic fresh, link_idle;

    // Link side, falling edges of sck_in.
    logic [7:0] out_byte;
    logic next_so, next_so_oe, next_io0, next_io0_oe;

    // Core side.
    sfc_pkg::sfc_state_t state, next_state;
    sfc_pkg::sfc_status_t next_status, sr_new, next_sr_new;
    logic [31:0] tick, next_tick, cyc_len;
    logic [23:0] op_addr, next_op_addr;
    logic [AW:0] prot_lim;
    logic [AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic cs_s1, cs_s2, cs_prev, wp_s1, wp_s2, tog_seen, next_tog_seen;
    logic cs_rise, hardware_protected_mode, prot_hit, full_bytes, mem_we;

    assign link_idle = cs_n_in | ~nrst_in;

    // The first rising edge of a frame sees fresh set and starts every count from zero.
    always_ff @(posedge sck_in or posedge link_idle) begin
        if (link_idle) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    always_comb begin
        cur_bits = fresh ? 3'h0 : frm.bits;
        cur_bytes = fresh ? 3'h0 : frm.bytes;
        cur_on = fresh ? 1'b0 : out_on;
        cur_mode = fresh ? sfc_pkg::RM_NONE : mode;
        step = (cur_on && cur_mode == sfc_pkg::RM_DUAL) ? 3'h2 : 3'h1;
        byte_done = (cur_bits == 3'(3'h0 - step));
        rx_byte = {shreg[6:0], io0_in};
        next_frm = frm;
        next_frm.bits = 3'(cur_bits + step);
        next_frm.bytes = cur_bytes;
        next_frm.tog = fresh ? ~frm.tog : frm.tog;
        next_mode = cur_mode;
        next_out_on = cur_on;
        next_prog_ok = fresh ? 1'b0 : prog_ok;
        next_sr_shadow = sr_shadow;
        next_rd_addr = rd_addr;
        next_pg_ptr = pg_ptr;
        next_pmask = pmask;
        pb_we = 1'b0;
        if (byte_done) begin
            if (cur_bytes != sfc_pkg::BYTES_SAT) begin
                next_frm.bytes = 3'(cur_bytes + 3'h1);
            end
            // Status is sampled once per byte so a byte never mixes two snapshots.
            next_sr_shadow = stat_s2;
            if (cur_on) begin
                next_rd_addr = 24'(rd_addr + 24'h1);
            end
            if (cur_bytes == 3'h0) begin
                next_frm.cmd = rx_byte;
                if (rx_byte == sfc_pkg::READ_STATUS_CMD) begin
                    next_mode = sfc_pkg::RM_STATUS;
                    next_out_on = 1'b1;
                end else if (stat_s2.write_in_progress) begin
                    next_mode = sfc_pkg::RM_NONE;
                end else if (rx_byte == sfc_pkg::READ_CMD) begin
                    next_mode = sfc_pkg::RM_READ;
                end else if (rx_byte == sfc_pkg::FAST_READ_CMD) begin
                    next_mode = sfc_pkg::RM_FAST;
                end else if (rx_byte == sfc_pkg::DUAL_READ_CMD) begin
                    next_mode = sfc_pkg::RM_DUAL;
                end
                // Buffering waits for a synced latch and an idle core, so a running
                // program never has its page buffer overwritten.
                if (rx_byte == sfc_pkg::PAGE_PROGRAM_CMD && stat_s2.write_enable_latch
                        && !stat_s2.write_in_progress) begin
                    next_prog_ok = 1'b1;
                    next_pmask = '0;
                end
            end else if (!cur_bytes[2]) begin
                next_frm.addr = {frm.addr[15:0], rx_byte};
                if (cur_bytes == sfc_pkg::ONE_BYTE) begin
                    next_frm.data = rx_byte;
                end
                if (cur_bytes == sfc_pkg::ADDR_LAST_BYTE) begin
                    next_rd_addr = {frm.addr[15:0], rx_byte};
                    next_pg_ptr = rx_byte;
                    next_out_on = (cur_mode == sfc_pkg::RM_READ);
                end
            end else begin
                if (cur_bytes == sfc_pkg::ADDR_FRAME_BYTES && (cur_mode == sfc_pkg::RM_FAST
                        || cur_mode == sfc_pkg::RM_DUAL)) begin
                    next_out_on = 1'b1;
                end
                if (prog_ok && !fresh) begin
                    pb_we = 1'b1;
                    next_pmask[pg_ptr] = 1'b1;
                    next_pg_ptr = 8'(pg_ptr + 8'h1);
                end
            end
        end
    end

    always_ff @(posedge sck_in or negedge nrst_in) begin
        if (!nrst_in) begin
            frm <= '0;
            mode <= sfc_pkg::RM_NONE;
            shreg <= 8'h00;
            sr_shadow <= 8'h00;
            rd_addr <= 24'h000000;
            pg_ptr <= 8'h00;
            pmask <= '0;
            out_on <= 1'b0;
            prog_ok <= 1'b0;
            stat_s1 <= sfc_pkg::STATUS_RESET;
            stat_s2 <= sfc_pkg::STATUS_RESET;
        end else begin
            frm <= next_frm;
            mode <= next_mode;
            shreg <= rx_byte;
            sr_shadow <= next_sr_shadow;
            rd_addr <= next_rd_addr;
            pg_ptr <= next_pg_ptr;
            pmask <= next_pmask;
            out_on <= next_out_on;
            prog_ok <= next_prog_ok;
            stat_s1 <= status_out;
            stat_s2 <= stat_s1;
        end
    end

    // A later byte for the same slot simply overwrites the earlier one.
    always_ff @(posedge sck_in) begin
        if (pb_we) begin
            pbuf[pg_ptr] <= rx_byte;
        end
    end

    // The array is only written while busy, and reads are refused while busy,
    // so this read of core-side storage from the link side sees settled data.
    always_comb begin
        out_byte = (mode == sfc_pkg::RM_STATUS) ? sr_shadow : mem[rd_addr[AW-1:0]];
        next_so = out_byte[3'(3'h7 - frm.bits)];
        next_io0 = out_byte[3'(3'h6 - frm.bits)];
        next_so_oe = out_on && !fresh;
        next_io0_oe = out_on && !fresh && (mode == sfc_pkg::RM_DUAL);
    end

    always_ff @(negedge sck_in or posedge link_idle) begin
        if (link_idle) begin
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
            io0_out <= 1'b0;
            io0_oe_out <= 1'b0;
        end else begin
            so_out <= next_so;
            so_oe_out <= next_so_oe;
            io0_out <= next_io0;
            io0_oe_out <= next_io0_oe;
        end
    end

    // The frame record is read only after synced chip select has risen; the
    // host no longer clocks then, so it holds still while it is read.
    always_comb begin
        cs_rise = cs_s2 && !cs_prev;
        hardware_protected_mode = status_out.status_protect_bit && !wp_s2;
        full_bytes = (frm.bits == 3'h0);
        prot_lim = (AW+1)'(MEM_BYTES)
            - ((AW+1)'(MEM_BYTES) >> (3'h7 - status_out.block_protect_bits));
        prot_hit = (status_out.block_protect_bits != 3'h0)
            && ({1'b0, frm.addr[AW-1:0]} >= prot_lim);
        next_state = state;
        next_status = status_out;
        next_sr_new = sr_new;
        next_tick = 32'(tick + 32'h1);
        next_op_addr = op_addr;
        next_tog_seen = cs_rise ? frm.tog : tog_seen;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = sfc_pkg::ERASED_BYTE;
        unique case (state)
            sfc_pkg::ST_WSTAT: cyc_len = TW_CYC;
            sfc_pkg::ST_PROG: cyc_len = TPP_CYC;
            sfc_pkg::ST_ERASE: cyc_len = TSE_CYC;
            sfc_pkg::ST_IDLE: cyc_len = 32'h1;
        endcase
        unique case (state)
            sfc_pkg::ST_IDLE: begin
                next_tick = 32'h0;
                if (cs_rise && frm.tog != tog_seen && full_bytes) begin
                    next_op_addr = frm.addr;
                    if (frm.bytes == sfc_pkg::ONE_BYTE
                            && frm.cmd == sfc_pkg::SET_WRITE_LATCH_CMD) begin
                        next_status.write_enable_latch = 1'b1;
                    end else if (frm.bytes == sfc_pkg::ONE_BYTE
                            && frm.cmd == sfc_pkg::CLEAR_WRITE_LATCH_CMD) begin
                        next_status.write_enable_latch = 1'b0;
                    end else if (!status_out.write_enable_latch) begin
                        next_state = sfc_pkg::ST_IDLE;
                    end else if (frm.cmd == sfc_pkg::WRITE_STATUS_CMD
                            && frm.bytes == sfc_pkg::STATUS_FRAME_BYTES && !hardware_protected_mode) begin
                        next_state = sfc_pkg::ST_WSTAT;
                        next_sr_new = frm.data;
                        next_status.write_in_progress = 1'b1;
                    end else if (frm.cmd == sfc_pkg::PAGE_PROGRAM_CMD && !prot_hit
                            && frm.bytes >= sfc_pkg::PROG_MIN_BYTES) begin
                        next_state = sfc_pkg::ST_PROG;
                        next_status.write_in_progress = 1'b1;
                        next_status.write_enable_latch = 1'b0;
                    end else if (frm.cmd == sfc_pkg::SECTOR_ERASE_CMD && !prot_hit
                            && frm.bytes == sfc_pkg::ADDR_FRAME_BYTES) begin
                        next_state = sfc_pkg::ST_ERASE;
                        next_status.write_in_progress = 1'b1;
                        next_status.write_enable_latch = 1'b0;
                    end
                end
            end
            sfc_pkg::ST_WSTAT: begin
                if (tick == cyc_len - 32'h1) begin
                    next_state = sfc_pkg::ST_IDLE;
                    next_status.block_protect_bits = sr_new.block_protect_bits;
                    next_status.status_protect_bit = sr_new.status_protect_bit;
                    next_status.write_enable_latch = 1'b0;
                    next_status.write_in_progress = 1'b0;
                end
            end
            sfc_pkg::ST_PROG: begin
                // The copy finishes long before the timed cycle, which must be
                // at least a page long in cycles.
                if (tick < sfc_pkg::PAGE_BYTES) begin
                    mem_we = pmask[tick[sfc_pkg::PAGE_AW-1:0]];
                    mem_wa = {op_addr[AW-1:sfc_pkg::PAGE_AW], tick[sfc_pkg::PAGE_AW-1:0]};
                    mem_wd = pbuf[tick[sfc_pkg::PAGE_AW-1:0]];
                end
                if (tick == cyc_len - 32'h1) begin
                    next_state = sfc_pkg::ST_IDLE;
                    next_status.write_in_progress = 1'b0;
                end
            end
            sfc_pkg::ST_ERASE: begin
                if (tick < sfc_pkg::SECTOR_BYTES) begin
                    mem_we = 1'b1;
                    mem_wa = {op_addr[AW-1:sfc_pkg::SECTOR_AW],
                        tick[sfc_pkg::SECTOR_AW-1:0]};
                end
                if (tick == cyc_len - 32'h1) begin
                    next_state = sfc_pkg::ST_IDLE;
                    next_status.write_in_progress = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_prev <= 1'b1;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
            tog_seen <= 1'b0;
            state <= sfc_pkg::ST_IDLE;
            status_out <= sfc_pkg::STATUS_RESET;
            sr_new <= sfc_pkg::STATUS_RESET;
            tick <= 32'h0;
            op_addr <= 24'h000000;
        end else begin
            cs_s1 <= cs_n_in;
            cs_s2 <= cs_s1;
            cs_prev <= cs_s2;
            wp_s1 <= wp_n_in;
            wp_s2 <= wp_s1;
            tog_seen <= next_tog_seen;
            state <= next_state;
            status_out <= next_status;
            sr_new <= next_sr_new;
            tick <= next_tick;
            op_addr <= next_op_addr;
        end
    end

    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end
endmodule

// file: sfc_flash_assertions.sv
// Concurrent checks on the flash command block, seen from its ports only.
// Assumes the core clock runs throughout and the host clocks the link only in frames.
`timescale 1ns/1ps
module sfc_flash_assertions (
    // Clocks and reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic sck_in,
    // Link inputs.
    input wire logic cs_n_in,
    input wire logic io0_in,
    input wire logic wp_n_in,
    // Link outputs and state.
    input wire logic io0_out,
    input wire logic io0_oe_out,
    input wire logic so_out,
    input wire logic so_oe_out,
    input wire sfc_pkg::sfc_status_t status_out
);
    property p_idle_quiet;
        @(posedge clk_in) disable iff (!nrst_in) cs_n_in |-> !so_oe_out && !io0_oe_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("data line driven while deselected");
    property p_zero_bits;
        @(posedge clk_in) disable iff (!nrst_in) status_out.zero == 2'b00;
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("reserved status bits not zero");
    property p_dual_pair;
        @(negedge sck_in) disable iff (cs_n_in) io0_oe_out |-> so_oe_out;
    endproperty
    a_dual_pair: assert property (p_dual_pair)
        else $error("second data line driven alone");
    property p_latch_done;
        @(posedge clk_in) disable iff (!nrst_in)
            $fell(status_out.write_in_progress) |-> !status_out.write_enable_latch;
    endproperty
    a_latch_done: assert property (p_latch_done)
        else $error("write latch still set after a cycle");
    property p_busy_hold;
        @(posedge clk_in) disable iff (!nrst_in)
            $rose(status_out.write_in_progress) |=> status_out.write_in_progress [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy flag dropped early");
    property p_busy_start;
        @(posedge clk_in) disable iff (!nrst_in)
            $rose(status_out.write_in_progress) |-> cs_n_in && $past(cs_n_in, 2);
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy rose inside a frame");
    property p_busy_frozen;
        @(posedge clk_in) disable iff (!nrst_in)
            status_out.write_in_progress && $past(status_out.write_in_progress) |->
            $stable({status_out[7], status_out.block_protect_bits, status_out[1]});
    endproperty
    a_busy_frozen: assert property (p_busy_frozen)
        else $error("status changed during a cycle");
    property p_protect_at_end;
        @(posedge clk_in) disable iff (!nrst_in)
            $changed({status_out[7], status_out.block_protect_bits}) |->
            $fell(status_out.write_in_progress);
    endproperty
    a_protect_at_end: assert property (p_protect_at_end)
        else $error("protect bits changed outside a status write");
endmodule

bind sfc_flash sfc_flash_assertions i_chk (.clk_in(clk_in), .nrst_in(nrst_in),
    .sck_in(sck_in), .cs_n_in(cs_n_in), .io0_in(io0_in), .wp_n_in(wp_n_in),
    .io0_out(io0_out), .io0_oe_out(io0_oe_out), .so_out(so_out),
    .so_oe_out(so_oe_out), .status_out(status_out));

// file: sfc_host.sv
// Host model of the serial link: frames commands, shifts bits in and out.
// Assumes mode 0 timing; the link clock rests low outside frames.
`timescale 1ns/1ps
module sfc_host (
    // Link clock, select and data to the device.
    output logic sck_out,
    output logic cs_n_out,
    output logic mosi_out,
    // Lines back from the device.
    input wire logic so_in,
    input wire logic io0_in,
    input wire logic so_oe_in
);
    logic oe_seen;
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        oe_seen = 1'b0;
    end
    // Only whole bits are sent, so a partial byte is exactly what the caller asked for.
    task automatic frame(input logic [7:0] tx[$], input int ntx, input int nrx,
                         input int dual, output logic [63:0] rx);
        rx = '0;
        oe_seen = 1'b0;
        cs_n_out = 1'b0;
        #6;
        for (int i = 0; i < ntx; i++) begin
            mosi_out = tx[i / 8][7 - i % 8];
            #6 sck_out = 1'b1;
            #6 sck_out = 1'b0;
        end
        // The host has let go of its data line here, so it changes every clock.
        for (int i = 0; i < nrx; i += (dual != 0) ? 2 : 1) begin
            mosi_out = ~mosi_out;
            #6 sck_out = 1'b1;
            oe_seen = oe_seen | so_oe_in;
            rx = (dual != 0) ? {rx[61:0], so_in, io0_in} : {rx[62:0], so_in};
            #6 sck_out = 1'b0;
        end
        #6 cs_n_out = 1'b1;
        #40;
    endtask
endmodule

// file: serial_flash_read_program_commands_bench.sv
// Self-checking bench for the flash command block, driven through the host model.
// Assumes shortened cycle times; the array is erased before anything is read back.
`timescale 1ns/1ps
module serial_flash_read_program_commands_bench;
    typedef struct {logic [63:0] tx; int ntx, nrx, dual, wp_n; logic [63:0] exp;} sfc_row_t;
    logic clk_in, nrst_in, wp_n_in, sck, cs_n, mosi, io0_line, so_line, busy;
    logic io0_out, io0_oe_out, so_out, so_oe_out;
    logic so_last = 1'b0;
    logic [63:0] rx;
    logic [7:0] q[$];
    logic [7:0] rd[$] = '{8'h03, 8'h00, 8'h10, 8'h00};
    sfc_pkg::sfc_status_t status_out;
    int error_cnt = 0;
    int total_checks = 0;
    sfc_row_t rows[29] = '{
        '{64'h05, 8, 16, 0, 1, 64'h0000},
        '{64'h011c, 16, 0, 0, 1, 64'h0},
        '{64'h06, 8, 0, 0, 1, 64'h0},
        '{64'h05, 8, 16, 0, 1, 64'h0202},
        '{64'h20000010, 32, 0, 0, 1, 64'h1},
        '{64'h05, 8, 8, 0, 1, 64'h00},
        '{64'h06, 8, 0, 0, 1, 64'h0},
        '{64'h02000ffeaabbcc, 56, 0, 0, 1, 64'h1},
        '{64'h03000f00, 32, 8, 0, 1, 64'hcc},
        '{64'h0b000ffe00, 40, 16, 0, 1, 64'haabb},
        '{64'h3b000ffe00, 40, 16, 1, 1, 64'haabb},
        '{64'h03000f01, 32, 8, 0, 1, 64'hff},
        '{64'h06, 8, 0, 0, 1, 64'h0},
        '{64'h01ff, 16, 0, 0, 1, 64'h1},
        '{64'h05, 8, 16, 0, 1, 64'h9c9c},
        '{64'h06, 8, 0, 0, 1, 64'h0},
        '{64'h02000f0111, 40, 0, 0, 1, 64'h0},
        '{64'h03000f01, 32, 8, 0, 1, 64'hff},
        '{64'h0100, 16, 0, 0, 0, 64'h0},
        '{64'h05, 8, 8, 0, 0, 64'h9e},
        '{64'h0100, 16, 0, 0, 1, 64'h1},
        '{64'h05, 8, 8, 0, 1, 64'h00},
        '{64'h06, 8, 0, 0, 1, 64'h0},
        '{64'h40000000, 33, 0, 0, 1, 64'h0},
        '{64'h1000780888, 43, 0, 0, 1, 64'h0},
        '{64'h03000f01, 32, 8, 0, 1, 64'hff},
        '{64'h05, 8, 8, 0, 1, 64'h02},
        '{64'h04, 8, 0, 0, 1, 64'h0},
        '{64'h05, 8, 8, 0, 1, 64'h00}
    };
    assign io0_line = io0_oe_out ? io0_out : mosi;
    // A released output shows the opposite of its last level, so no stale value can pass.
    assign so_line = so_oe_out ? so_out : ~so_last;
    always @(posedge sck) so_last <= so_line;
    sfc_host i_host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .so_in(so_line),
        .io0_in(io0_line), .so_oe_in(so_oe_out));
    sfc_flash #(.TW_CYC(200), .TPP_CYC(300), .TSE_CYC(4200)) i_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .sck_in(sck), .cs_n_in(cs_n),
        .io0_in(io0_line), .wp_n_in(wp_n_in), .io0_out(io0_out), .io0_oe_out(io0_oe_out),
        .so_out(so_out), .so_oe_out(so_oe_out), .status_out(status_out));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic check_data(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // One frame, then status polls until idle; busy tells whether the first poll saw a cycle.
    task automatic run(input logic [63:0] w, input int ntx, input int nrx, input int dual,
                       output logic [63:0] got, output logic bsy);
        logic [7:0] bq[$];
        logic [7:0] rs[$] = '{8'h05};
        logic [63:0] st;
        w = w << (64 - ntx);
        for (int i = 0; i * 8 < ntx; i++) bq.push_back(w[63 - 8 * i -: 8]);
        i_host.frame(bq, ntx, nrx, dual, got);
        i_host.frame(rs, 8, 8, 0, st);
        bsy = st[0];
        for (int n = 0; n < 3000 && st[0] !== 1'b0; n++) i_host.frame(rs, 8, 8, 0, st);
        // A poll that never sees the cycle end counts as a mismatch.
        check_flag(st[0], 1'b0);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #250us;
        error_cnt++;
        test_done;
    end
    initial begin
        nrst_in = 1'b0;
        wp_n_in = 1'b1;
        repeat (20) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        check_data(status_out, 64'h00);
        repeat (3) @(posedge clk_in);
        foreach (rows[i]) begin
            @(posedge clk_in);
            #1 wp_n_in = rows[i].wp_n[0];
            run(rows[i].tx, rows[i].ntx, rows[i].nrx, rows[i].dual, rx, busy);
            if (rows[i].nrx > 0) check_data(rx, rows[i].exp);
            else check_flag(busy, rows[i].exp[0]);
        end
        // Longer than a page: only the last page worth of bytes may survive.
        q = '{8'h02, 8'h00, 8'h10, 8'h00};
        for (int k = 0; k < 258; k++) q.push_back(k < 2 ? 8'h00 : (k < 256 ? 8'h33 : 8'h77));
        run(64'h06, 8, 0, 0, rx, busy);
        run(64'h20001000, 32, 0, 0, rx, busy);
        run(64'h06, 8, 0, 0, rx, busy);
        i_host.frame(q, 8 * 262, 0, 0, rx);
        i_host.frame(rd, 32, 8, 0, rx);
        check_flag(i_host.oe_seen, 1'b0);
        run(64'h05, 8, 8, 0, rx, busy);
        run(64'h03001000, 32, 24, 0, rx, busy);
        check_data(rx, 64'h777733);
        run(64'h06, 8, 0, 0, rx, busy);
        @(posedge clk_in);
        #1 nrst_in = 1'b0;
        repeat (20) @(posedge clk_in);
        check_data(status_out, 64'h00);
        #1 nrst_in = 1'b1;
        repeat (3) @(posedge clk_in);
        run(64'h05, 8, 8, 0, rx, busy);
        check_data(rx, 64'h00);
        test_done;
    end
endmodule
